// ### gtc_timer.sv
// Gated 16-bit timer/counter with its AHB-Lite register slave.
//
// Function
// - 16-bit up-counter accessed as two bytes; a byte write loads immediately.
// - Source select 0 picks instruction clock, 1 picks external count input.
// - Internal source advances once per prescaled number of instruction cycles.
// - External counting advances on rising edges of the count input.
// - External mode offers synchronized or asynchronous counting.
// - No rising edge counts until a falling edge has been seen.
// - Prescaler divides the selected clock by 1, 2, 4 or 8.
// - Prescale counter is hidden and cleared by any counter byte write.
// - Oscillator enable starts the low-power oscillator; it runs through sleep.
// - Oscillator usable only with internal or low-power system clock.
// - Oscillator enabled forces pins 5 and 4 to input; directions 1, data 0; forced here only while osc_mode_allows_timer is set.
// - Bypass bit counts the external input without phase alignment.
// - Asynchronous mode keeps counting in sleep; rollover can wake the core.
// - Mode switches may lose or add one increment; both are accepted.
// - Divide select 11 is 8, 10 is 4, 01 is 2, 00 is 1.
// - Rollover from maximum to zero sets a sticky flag cleared by software.
// - Bypass bit is ignored while the internal source is selected.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gtc_timer
    import gtc_pkg::*;
(
    // Clock and reset
    input  wire  logic        clock,
    input  wire  logic        reset_n,
    // AHB-Lite slave
    input  wire  logic        hsel,
    input  wire  logic [7:0]  haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output var   logic        hreadyout,
    output var   logic        hresp,
    output var   logic [31:0] hrdata,
    // Count sources and system state
    input  wire  logic        external_count_input,
    input  wire  logic        lp_osc_clock_in,
    input  wire  logic        osc_mode_allows_timer,
    input  wire  logic        sleep_active,
    // Port pins, oscillator run and wake request
    input  wire  logic [5:0]  pin_levels,
    output var   logic [5:0]  pin_direction,
    output var   logic        lp_osc_run,
    output var   logic        wake_request
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    gtc_ctrl_t   ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        rollover_flag_reg;
    logic [5:0]  pdir_reg;
    logic [2:0]  pre_reg;
    logic [2:0]  pre_next;
    logic [1:0]  instr_reg;
    logic [2:0]  ext_sync_reg;
    logic        ext_level_reg;
    logic        armed_reg;
    logic        pre_tgl_reg;
    logic [2:0]  tgl_sync_reg;
    logic [5:0]  pin_s1_reg;
    logic [5:0]  pin_s2_reg;
    logic [5:0]  pin_s3_reg;
    logic [5:0]  pin_view_reg;
    logic        ph_valid_reg;
    logic        ph_write_reg;
    logic [7:0]  ph_addr_reg;
    logic        hreadyout_reg;
    logic        hresp_reg;
    logic [31:0] hrdata_reg;
    logic        run_reg;
    logic        wake_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire         addr_phase   = hsel & hready & (htrans == GTC_HTRANS_NSEQ);
    wire         wr_now       = ph_valid_reg & ph_write_reg;
    wire         wr_low       = wr_now & (ph_addr_reg == GTC_ADDR_LOW);
    wire         wr_high      = wr_now & (ph_addr_reg == GTC_ADDR_HIGH);
    wire         wr_ctrl      = wr_now & (ph_addr_reg == GTC_ADDR_CTRL);
    wire         wr_status    = wr_now & (ph_addr_reg == GTC_ADDR_STATUS);
    wire         wr_pdir      = wr_now & (ph_addr_reg == GTC_ADDR_PDIR);
    wire         wr_count     = wr_low | wr_high;

    // ----------------------------------------------------------------
    // Source selection and prescaling
    // ----------------------------------------------------------------
    wire         osc_active   = ctrl_reg.low_power_osc_enable & osc_mode_allows_timer;
    wire         ext_raw      = osc_active ? lp_osc_clock_in : external_count_input;
    wire         ext_agree    = ext_sync_reg[1] == ext_sync_reg[2];
    wire         ext_rise     = ext_agree & ext_sync_reg[2] & ~ext_level_reg;
    wire         ext_fall     = ext_agree & ~ext_sync_reg[2] & ext_level_reg;
    wire         ext_mode     = ctrl_reg.count_source_select;
    wire         async_mode   = ext_mode & ctrl_reg.sync_bypass;
    wire         instr_tick   = (instr_reg == GTC_INSTR_LAST) & ~sleep_active;
    wire         ext_tick     = ext_rise & armed_reg;
    wire         src_tick     = ext_mode ? ext_tick : instr_tick;
    wire [2:0]   pre_mask     = 3'((4'h1 << ctrl_reg.input_divide_select) - 4'h1);
    wire         pre_done     = src_tick & ((pre_reg & pre_mask) == pre_mask);
    wire         sync_path    = ext_mode & ~ctrl_reg.sync_bypass;
    wire         tgl_edge     = tgl_sync_reg[1] ^ tgl_sync_reg[2];
    wire         sync_inc     = sync_path & tgl_edge & ~sleep_active;
    wire         direct_inc   = pre_done & ~sync_path;
    wire         count_inc    = ctrl_reg.counter_on & (direct_inc | sync_inc);
    // A byte write in the same cycle overrides the count, so no rollover is flagged.
    wire         roll_event   = count_inc & ~wr_count & (count_reg == 16'hffff);

    // A write to either byte wins over a coinciding increment.
    always_comb
    begin
        count_next = count_reg;
        if (wr_low)
        begin
            count_next = {count_reg[15:8], hwdata[7:0]};
        end
        else if (wr_high)
        begin
            count_next = {hwdata[7:0], count_reg[7:0]};
        end
        else if (count_inc)
        begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_comb
    begin
        pre_next = pre_reg;
        if (wr_count)
        begin
            pre_next = 3'h0;
        end
        else if (pre_done)
        begin
            pre_next = 3'h0;
        end
        else if (src_tick)
        begin
            pre_next = pre_reg + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Read view
    // ----------------------------------------------------------------
    // A pin change is taken once the second and third stages agree.
    wire [5:0]   pin_keep     = ~(pin_s2_reg ^ pin_s3_reg);
    wire [5:0]   pin_view_next = (pin_keep & pin_s3_reg) | (~pin_keep & pin_view_reg);
    wire [5:0]   osc_pin_mask = (6'h1 << GTC_OSC_PIN_HI) | (6'h1 << GTC_OSC_PIN_LO);
    wire [5:0]   pdir_view    = osc_active ? (pdir_reg | osc_pin_mask) : pdir_reg;
    wire [5:0]   pdata_view   = osc_active ? (pin_view_reg & ~osc_pin_mask) : pin_view_reg;
    wire [7:0]   stat_view    = {7'h00, rollover_flag_reg};
    wire [7:0]   rd_byte      = (haddr == GTC_ADDR_LOW)    ? count_reg[7:0]  :
                                (haddr == GTC_ADDR_HIGH)   ? count_reg[15:8] :
                                (haddr == GTC_ADDR_CTRL)   ? ctrl_reg        :
                                (haddr == GTC_ADDR_STATUS) ? stat_view       :
                                (haddr == GTC_ADDR_PDIR)   ? {2'h0, pdir_view} :
                                (haddr == GTC_ADDR_PDATA)  ? {2'h0, pdata_view} :
                                8'h00;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ph_valid_reg  <= 1'b0;
            ph_write_reg  <= 1'b0;
            ph_addr_reg   <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
            hresp_reg     <= 1'b0;
        end
        else
        begin
            ph_valid_reg  <= addr_phase;
            ph_write_reg  <= hwrite;
            ph_addr_reg   <= haddr;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
            if (addr_phase & ~hwrite)
            begin
                hrdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg          <= GTC_CTRL_RESET;
            pdir_reg          <= GTC_PDIR_RESET;
            rollover_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_reg <= {2'h0, hwdata[5:0]};
            end
            if (wr_pdir)
            begin
                pdir_reg <= hwdata[5:0];
            end
            if (roll_event)
            begin
                rollover_flag_reg <= 1'b1;
            end
            else if (wr_status & hwdata[GTC_STAT_ROLL])
            begin
                rollover_flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter and prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= 16'h0000;
            pre_reg   <= 3'h0;
            instr_reg <= 2'h0;
        end
        else
        begin
            count_reg <= count_next;
            pre_reg   <= pre_next;
            instr_reg <= instr_reg + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // External input synchronizer and edge arming
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_sync_reg  <= 3'h0;
            ext_level_reg <= 1'b0;
            armed_reg     <= 1'b0;
        end
        else
        begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_raw};
            if (ext_agree)
            begin
                ext_level_reg <= ext_sync_reg[2];
            end
            if (!ext_mode)
            begin
                armed_reg <= 1'b0;
            end
            else if (ext_fall)
            begin
                armed_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Synchronized count path
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pre_tgl_reg  <= 1'b0;
            tgl_sync_reg <= 3'h0;
        end
        else
        begin
            if (pre_done & sync_path)
            begin
                pre_tgl_reg <= ~pre_tgl_reg;
            end
            // Mode switches can drop or add one count here, which is accepted.
            tgl_sync_reg <= {tgl_sync_reg[1:0], pre_tgl_reg};
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronizer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_s1_reg   <= 6'h00;
            pin_s2_reg   <= 6'h00;
            pin_s3_reg   <= 6'h00;
            pin_view_reg <= 6'h00;
        end
        else
        begin
            pin_s1_reg   <= pin_levels;
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_view_reg <= pin_view_next;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_direction <= GTC_PDIR_RESET;
            run_reg       <= 1'b0;
            wake_reg      <= 1'b0;
        end
        else
        begin
            pin_direction <= pdir_view;
            run_reg       <= osc_active;
            wake_reg      <= roll_event & sleep_active & async_mode;
        end
    end

    assign hreadyout    = hreadyout_reg;
    assign hresp        = hresp_reg;
    assign hrdata       = hrdata_reg;
    assign lp_osc_run   = run_reg;
    assign wake_request = wake_reg;
endmodule : gtc_timer
`default_nettype wire

// ### gtc_pkg.sv
// Shared constants and types for the gated 16-bit timer/counter.
`default_nettype none
package gtc_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] GTC_ADDR_LOW    = 8'h00;
    localparam logic [7:0] GTC_ADDR_HIGH   = 8'h04;
    localparam logic [7:0] GTC_ADDR_CTRL   = 8'h08;
    localparam logic [7:0] GTC_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] GTC_ADDR_PDIR   = 8'h10;
    localparam logic [7:0] GTC_ADDR_PDATA  = 8'h14;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         GTC_CTRL_ON     = 0;
    localparam int         GTC_CTRL_SRC    = 1;
    localparam int         GTC_CTRL_BYP    = 2;
    localparam int         GTC_CTRL_OSC    = 3;
    localparam int         GTC_CTRL_DIV_LO = 4;
    localparam int         GTC_STAT_ROLL   = 0;
    localparam int         GTC_OSC_PIN_HI  = 5;
    localparam int         GTC_OSC_PIN_LO  = 4;
    localparam logic [7:0] GTC_CTRL_RESET  = 8'h00;
    localparam logic [5:0] GTC_PDIR_RESET  = 6'h3f;
    localparam logic [1:0] GTC_INSTR_LAST  = 2'h3;
    localparam logic [1:0] GTC_HTRANS_NSEQ = 2'h2;
    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       unused7;
        logic       unused6;
        logic [1:0] input_divide_select;
        logic       low_power_osc_enable;
        logic       sync_bypass;
        logic       count_source_select;
        logic       counter_on;
    } gtc_ctrl_t;
endpackage : gtc_pkg
`default_nettype wire

// ### gtc_properties.sv
// Concurrent checks on the timer/counter ports.
`timescale 1ns/100ps
`default_nettype none
module gtc_properties
    import gtc_pkg::*;
(
    // Clock, reset and bus
    input  wire  logic        clock,
    input  wire  logic        reset_n,
    input  wire  logic        hsel,
    input  wire  logic [7:0]  haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    input  wire  logic [31:0] hrdata,
    // Oscillator, sleep and pins
    input  wire  logic        osc_mode_allows_timer,
    input  wire  logic        sleep_active,
    input  wire  logic [5:0]  pin_direction,
    input  wire  logic        lp_osc_run,
    input  wire  logic        wake_request
);
    // ----------------------------------------------------------------
    // Shadow of the control register and the checks.
    // ----------------------------------------------------------------
    logic       take;
    logic       rd;
    logic       wr_reg;
    logic [7:0] wa_reg;
    logic [7:0] ctrl_reg;
    assign take = hsel && hready && htrans == GTC_HTRANS_NSEQ;
    assign rd   = take && !hwrite;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_reg   <= 1'b0;
            wa_reg   <= 8'h00;
            ctrl_reg <= GTC_CTRL_RESET;
        end
        else
        begin
            wr_reg <= take && hwrite;
            wa_reg <= haddr;
            if (wr_reg && wa_reg == GTC_ADDR_CTRL)
                ctrl_reg <= hwdata[7:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_osc_pins_input: assert property (lp_osc_run |-> pin_direction[5:4] == 2'h3)
        else $error("Oscillator active but pins 5 and 4 not input.");
    a_osc_mode_blocks: assert property (!osc_mode_allows_timer [*3] |-> !lp_osc_run)
        else $error("Oscillator runs in a disallowed clock mode.");
    a_osc_starts: assert property ((ctrl_reg[3] && osc_mode_allows_timer) [*3] |-> lp_osc_run)
        else $error("Oscillator did not start.");
    a_osc_stops: assert property (!ctrl_reg[3] [*3] |-> !lp_osc_run)
        else $error("Oscillator runs with enable clear.");
    a_ctrl_readback: assert property (rd && haddr == GTC_ADDR_CTRL && !wr_reg
        |=> hrdata[7:0] == {2'h0, $past(ctrl_reg[5:0])}) else $error("Control read wrong.");
    a_byte_reads: assert property (rd |=> hrdata[31:8] == 24'h0)
        else $error("Read data above the byte not zero.");
    a_pin_data_zero: assert property (rd && haddr == GTC_ADDR_PDATA && lp_osc_run
        && $past(lp_osc_run) |=> hrdata[5:4] == 2'h0) else $error("Pin data 5:4 not zero.");
    a_wake_in_sleep: assert property (wake_request |-> $past(sleep_active))
        else $error("Wake request outside sleep.");
    a_wake_mode: assert property (wake_request |-> $past(ctrl_reg[2:0]) == 3'h7)
        else $error("Wake request outside asynchronous counting.");
    a_wake_single: assert property (wake_request |=> !wake_request)
        else $error("Wake request longer than one cycle.");
endmodule : gtc_properties
bind gtc_timer gtc_properties u_props (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .osc_mode_allows_timer(osc_mode_allows_timer),
    .sleep_active(sleep_active), .pin_direction(pin_direction), .lp_osc_run(lp_osc_run),
    .wake_request(wake_request));
`default_nettype wire

// ### gtc_count_source.sv
// Behavioural source for the external count pin.
`timescale 1ns/100ps
`default_nettype none
module gtc_count_source
(
    // Count pin
    output var   logic level
);
    // ----------------------------------------------------------------
    // Pin starts low so that its first edge is a rise.
    // ----------------------------------------------------------------
    initial level = 1'b0;
    task automatic pulses(input int n, input int half_ns);
        for (int i = 0; i < n; i++)
        begin
            #(half_ns) level = 1'b1;
            #(half_ns) level = 1'b0;
        end
    endtask : pulses
endmodule : gtc_count_source
`default_nettype wire

// ### test_gtc_timer.sv
// Self-checking bench for the gated 16-bit timer/counter.
`timescale 1ns/100ps
`default_nettype none
module test_gtc_timer
    import gtc_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus, queued expectations and the read monitor.
    // ----------------------------------------------------------------
    logic        clock, reset_n, hsel, hwrite, hreadyout, hresp, ext_in, allow, sleep;
    logic        osc_run, wake, rd_phase, osc_in;
    logic [1:0]  htrans;
    logic [7:0]  haddr;
    logic [5:0]  pins, pdir;
    logic [31:0] hwdata, hrdata, v;
    logic [7:0]  lo_q[$], span_q[$];
    int          fails, n_checks, seed, wake_cnt, wake_base;
    gtc_timer dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_count_input(ext_in),
        .lp_osc_clock_in(osc_in), .osc_mode_allows_timer(allow), .sleep_active(sleep),
        .pin_levels(pins), .pin_direction(pdir), .lp_osc_run(osc_run), .wake_request(wake));
    gtc_count_source src (.level(ext_in));
    gtc_count_source osc (.level(osc_in));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    always @(posedge clock)
    begin
        if (!reset_n)
            wake_cnt <= 0;
        else if (wake === 1'b1)
            wake_cnt <= wake_cnt + 1;
        if (rd_phase === 1'b1 && hreadyout === 1'b1)
        begin
            check((hrdata >= lo_q[0] && hrdata <= lo_q[0] + span_q[0]) ? lo_q[0] : hrdata,
                  {24'h0, lo_q[0]});
            void'(lo_q.pop_front());
            void'(span_q.pop_front());
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= GTC_HTRANS_NSEQ;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans   <= 2'h0;
        hsel     <= 1'b0;
        hwdata   <= {24'h0, d};
        rd_phase <= !w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] span);
        lo_q.push_back(lo);
        span_q.push_back(span);
        bus(1'b0, a, 8'h00);
    endtask : rd
    initial
    begin
        #1_000_000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        {seed, fails, n_checks} = {32'd38, 32'd0, 32'd0};
        {reset_n, hsel, hwrite, rd_phase, allow, sleep} = 6'h0;
        {htrans, haddr, hwdata, pins} = {2'h0, 8'h00, 32'h0, 6'h3f};
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(GTC_ADDR_CTRL, GTC_CTRL_RESET, 8'h0);
        rd(GTC_ADDR_PDIR, {2'h0, GTC_PDIR_RESET}, 8'h0);
        rd(GTC_ADDR_STATUS, 8'h00, 8'h0);
        rd(8'h18, 8'h00, 8'h0);
        $display("Reset values done.");
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(GTC_ADDR_LOW, v[7:0]);
            wr(GTC_ADDR_HIGH, v[15:8]);
            rd(GTC_ADDR_LOW, v[7:0], 8'h0);
            rd(GTC_ADDR_HIGH, v[15:8], 8'h0);
        end
        $display("Byte access done.");
        for (int s = 0; s < 4; s++)
        begin
            wr(GTC_ADDR_HIGH, 8'h00);
            wr(GTC_ADDR_CTRL, {2'h0, 2'(s), 1'b0, s[0], 2'h1});
            wr(GTC_ADDR_LOW, 8'h00);
            repeat (96 << s) @(posedge clock);
            wr(GTC_ADDR_CTRL, 8'h00);
            rd(GTC_ADDR_LOW, 8'd23, 8'd3);
        end
        $display("Prescaler done.");
        wr(GTC_ADDR_CTRL, 8'h01);
        wr(GTC_ADDR_HIGH, 8'hff);
        wr(GTC_ADDR_LOW, 8'hf8);
        repeat (40) @(posedge clock);
        rd(GTC_ADDR_STATUS, 8'h01, 8'h0);
        wr(GTC_ADDR_STATUS, 8'h01);
        rd(GTC_ADDR_STATUS, 8'h00, 8'h0);
        rd(GTC_ADDR_HIGH, 8'h00, 8'h0);
        wr(GTC_ADDR_CTRL, 8'h00);
        $display("Rollover done.");
        wr(GTC_ADDR_PDIR, 8'h00);
        for (int a = 0; a < 2; a++)
        begin
            v = $random(seed);
            allow <= a[0];
            pins  <= v[5:0];
            wr(GTC_ADDR_CTRL, 8'h08);
            repeat (20) @(posedge clock);
            check(osc_run, a[0]);
            check(pdir, {a[0], a[0], 4'h0});
            rd(GTC_ADDR_PDIR, {2'h0, a[0], a[0], 4'h0}, 8'h0);
            rd(GTC_ADDR_PDATA, {2'h0, v[5:4] & ~{a[0], a[0]}, v[3:0]}, 8'h0);
            wr(GTC_ADDR_LOW, 8'h00);
            wr(GTC_ADDR_CTRL, 8'h0f);
            osc.pulses(3, 310);
            repeat (10) @(posedge clock);
            wr(GTC_ADDR_CTRL, 8'h08);
            rd(GTC_ADDR_LOW, {6'h0, a[0], 1'b0}, 8'h0);
        end
        wr(GTC_ADDR_CTRL, 8'h00);
        $display("Oscillator done.");
        for (int b = 0; b < 2; b++)
        begin
            wr(GTC_ADDR_HIGH, 8'hff);
            wr(GTC_ADDR_LOW, 8'hff);
            wake_base = wake_cnt;
            sleep <= b[0];
            wr(GTC_ADDR_CTRL, {5'h0, b[0], 2'h3});
            src.pulses(5, 310 + 200 * b);
            repeat (10) @(posedge clock);
            sleep <= 1'b0;
            wr(GTC_ADDR_CTRL, 8'h00);
            rd(GTC_ADDR_LOW, 8'h03, 8'h0);
            check(wake_cnt - wake_base, b[0]);
        end
        $display("External counting done.");
        report_and_stop();
    end
endmodule : test_gtc_timer
`default_nettype wire
